// file: hdl/dsw_interp.sv
// Purpose: Third-order comb interpolator on the bit clock
// Assumes: Exactly one load per sixteen edges while running
// Notes:   Wrapping integrators rely on a steady frame length
`timescale 1ns/1ps
`default_nettype none
module dsw_interp #(
   parameter int W     = 16,
   parameter int ACC_W = 28
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         clr,
   input  wire logic         load,
   input  wire logic [W-1:0] sample,
   input  wire logic [2:0]   ratio_log2,
   output logic      [W-1:0] code,
   output logic              tick
);
   logic signed [ACC_W-1:0] x_in, c1, c2, c3, imp;
   logic signed [ACC_W-1:0] x1_r, d1_r, d2_r, i1_r, i2_r, i3_r;
   logic signed [ACC_W-1:0] scaled;
   logic        [3:0]       cnt_r;
   logic        [3:0]       mask;
   logic                    tick_w;

   assign x_in   = ACC_W'(signed'(sample));
   assign c1     = x_in - x1_r;
   assign c2     = c1 - d1_r;
   assign c3     = c2 - d2_r;
   assign imp    = load ? c3 : '0;
   assign mask   = 4'hf >> ratio_log2;
   assign tick_w = load | ((cnt_r & mask) == 4'h0);
   // Gain of the zero-stuffed chain is ratio squared
   assign scaled = i3_r >>> {ratio_log2, 1'b0};

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         {x1_r, d1_r, d2_r} <= '0;
         {i1_r, i2_r, i3_r} <= '0;
         cnt_r <= 4'h0;
         code  <= '0;
         tick  <= 1'b0;
      end else if (clr) begin
         {x1_r, d1_r, d2_r} <= '0;
         {i1_r, i2_r, i3_r} <= '0;
         cnt_r <= 4'h0;
         code  <= '0;
         tick  <= 1'b0;
      end else begin
         cnt_r <= load ? 4'h1 : cnt_r + 4'h1;
         tick  <= tick_w;
         if (load) begin
            x1_r <= x_in;
            d1_r <= c1;
            d2_r <= c2;
         end
         if (tick_w) begin
            i1_r <= i1_r + imp;
            i2_r <= i2_r + i1_r;
            i3_r <= i3_r + i2_r;
            code <= scaled[W-1:0];
         end
      end
   end

   property p_clr_mid;
      @(posedge clk) disable iff (rst)
      clr |=> (code == '0) && !tick;
   endproperty
   a_clr_mid: assert property (p_clr_mid) else $error("filter clear left code off mid");

   property p_tick16;
      @(posedge clk) disable iff (rst)
      (!clr && ratio_log2 == 3'h4) |=> tick;
   endproperty
   a_tick16: assert property (p_tick16) else $error("16x ratio missed an output point");

   property p_tick2;
      @(posedge clk) disable iff (rst)
      (tick_w && !clr && ratio_log2 == 3'h1)
      ##1 (!load && !clr && ratio_log2 == 3'h1)[*8] |-> tick_w;
   endproperty
   a_tick2: assert property (p_tick2) else $error("2x ratio period not eight edges");
endmodule
`default_nettype wire

// file: hdl/dsw_sync.sv
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Each bit is an independent level or toggle
// Notes:   Output follows once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module dsw_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;
   logic [W-1:0] q_nxt;

   assign q_nxt = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & q);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         q    <= '0;
      end else begin
         s1_r <= d;
         s2_r <= s1_r;
         s3_r <= s2_r;
         q    <= q_nxt;
      end
   end
endmodule
`default_nettype wire

// file: hdl/dsw_top.sv
// Purpose: Serial word input, holding register and output latch
// Assumes: Bit clock and word sync come from the host together
// Notes:   Control pins are resynchronised into the bit clock
// What this block does
// - Serial data shifts into a 16-bit register on every bit-clock rise.
// - A falling word sync copies the last 16 shifted bits to the holding register.
// - The second bit-clock rise after that fall moves the word to latch or filter.
// - With the filter off the code updates 1.5 bit periods after the fall.
// - Words arrive most significant bit first and are kept that way.
// - Codes are two's complement with 0000 as mid-scale.
// - The output path is held at mid-scale until about 30 us after power-up.
// - The filter offers selectable ratio, bypass and full disable.
// - At ratio 16 the filter makes fifteen points between host samples.
// - With the filter disabled and bypass low it is a plain one-word-per-frame converter.
// - Low mute forces mid-scale at the update after a word-sync fall.
// - Ratios 2, 4, 8, 16 give a new output every 8, 4, 2, 1 rises.
// - Bypass low and filter reset low without mute is standard operation.
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module dsw_top (
   input  wire logic                        clk_sys,
   input  wire logic                        rst,
   input  wire logic                        clk_bit,
   input  wire logic                        serial_data_in,
   input  wire logic                        word_sync,
   input  wire logic                        mute_n,
   input  wire logic                        filter_bypass_n,
   input  wire logic                        filter_reset_n,
   input  wire logic [1:0]                  oversampling_ratio,
   input  wire logic [dsw_pkg::ADDR_W-1:0]  reg_addr,
   input  wire logic [dsw_pkg::DATA_W-1:0]  reg_wdata,
   input  wire logic                        reg_wr,
   input  wire logic                        reg_rd,
   output logic      [dsw_pkg::DATA_W-1:0]  reg_rdata,
   output logic      [dsw_pkg::WORD_W-1:0]  dac_code,
   output logic                             dac_update
);
   localparam int W = dsw_pkg::WORD_W;

   // System clock side
   logic                       ctrl_smute_r;
   dsw_pkg::dsw_por_t          por_st_r;
   dsw_pkg::dsw_por_t          por_st_nxt;
   logic [dsw_pkg::POR_W-1:0]  por_cnt_r;
   logic [dsw_pkg::POR_W-1:0]  por_cnt_nxt;
   logic                       por_done;
   logic                       req_r;
   logic                       ack_s;
   logic                       snap_take;
   dsw_pkg::dsw_snap_t         code_sys_r;
   logic                       hit_ctrl;
   logic                       hit_code;
   logic                       hit_stat;
   logic [dsw_pkg::DATA_W-1:0] rd_mux;
   logic [dsw_pkg::DATA_W-1:0] reg_rdata_r;

   // Bit clock side
   dsw_pkg::dsw_ctl_t          ctl_raw;
   dsw_pkg::dsw_ctl_t          ctl_s;
   logic [W-1:0]               shift_r;
   logic                       ws_d_r;
   logic                       ws_fall;
   logic [W-1:0]               hold_r;
   logic                       xfer_r;
   logic                       mute_on;
   dsw_pkg::dsw_mode_t         mode;
   logic [W-1:0]               dac_code_r;
   logic [W-1:0]               dac_nxt;
   logic                       dac_update_r;
   logic                       upd_nxt;
   logic [2:0]                 ratio_log2;
   logic                       f_clr;
   logic                       f_load;
   logic [W-1:0]               f_code;
   logic                       f_tick;
   dsw_pkg::dsw_snap_t         snap_r;
   logic                       ack_r;
   logic [4:0]                 warm_r;

   assign por_done = (por_st_r == dsw_pkg::POR_DONE);

   assign por_cnt_nxt = (por_st_r == dsw_pkg::POR_WAIT) ?
                        por_cnt_r + 10'h001 : por_cnt_r;

   always_comb begin
      por_st_nxt = por_st_r;
      case (por_st_r)
         dsw_pkg::POR_WAIT: begin
            if (por_cnt_r == dsw_pkg::POR_W'(dsw_pkg::POR_CYC - 1)) begin
               por_st_nxt = dsw_pkg::POR_DONE;
            end
         end
         dsw_pkg::POR_DONE: begin
            por_st_nxt = dsw_pkg::POR_DONE;
         end
         default: begin
            por_st_nxt = dsw_pkg::POR_WAIT;
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         por_st_r  <= dsw_pkg::POR_WAIT;
         por_cnt_r <= '0;
      end else begin
         por_st_r  <= por_st_nxt;
         por_cnt_r <= por_cnt_nxt;
      end
   end

   // Snapshot handshake: the bit side holds snap_r still until req moves
   assign snap_take = (ack_s == req_r);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         req_r      <= 1'b0;
         code_sys_r <= '0;
      end else if (snap_take) begin
         req_r      <= ~req_r;
         code_sys_r <= snap_r;
      end
   end

   assign hit_ctrl = (reg_addr == dsw_pkg::OFF_CTRL);
   assign hit_code = (reg_addr == dsw_pkg::OFF_CODE);
   assign hit_stat = (reg_addr == dsw_pkg::OFF_STAT);

   assign rd_mux = hit_ctrl ? {31'h0, ctrl_smute_r} :
                   hit_code ? {16'h0, code_sys_r.code} :
                   hit_stat ? {28'h0, code_sys_r.mode, por_done} :
                   32'h0;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ctrl_smute_r <= dsw_pkg::CTRL_SMUTE_RST;
         reg_rdata_r  <= '0;
      end else begin
         if (reg_wr && hit_ctrl) begin
            ctrl_smute_r <= reg_wdata[dsw_pkg::CTRL_SMUTE_BIT];
         end
         reg_rdata_r <= reg_rd ? rd_mux : 32'h0;
      end
   end

   assign reg_rdata = reg_rdata_r;

   dsw_sync #(
      .W (1)
   ) u_sync_ack (
      .clk (clk_sys),
      .rst (rst),
      .d   (ack_r),
      .q   (ack_s)
   );

   // Control pins and system-side levels all cross into the bit clock here
   assign ctl_raw.mute_n   = mute_n;
   assign ctl_raw.bypass_n = filter_bypass_n;
   assign ctl_raw.freset_n = filter_reset_n;
   assign ctl_raw.ratio    = oversampling_ratio;
   assign ctl_raw.smute    = ctrl_smute_r;
   assign ctl_raw.por_ok   = por_done;
   assign ctl_raw.req      = req_r;

   dsw_sync #(
      .W ($bits(dsw_pkg::dsw_ctl_t))
   ) u_sync_ctl (
      .clk (clk_bit),
      .rst (rst),
      .d   (ctl_raw),
      .q   (ctl_s)
   );

   // Word sync is launched with the bit clock, so it is sampled directly
   assign ws_fall = ws_d_r & ~word_sync;

   always_ff @(posedge clk_bit or posedge rst) begin
      if (rst) begin
         shift_r <= '0;
         ws_d_r  <= 1'b0;
         hold_r  <= dsw_pkg::MID_CODE;
         xfer_r  <= 1'b0;
      end else begin
         shift_r <= {shift_r[W-2:0], serial_data_in};
         ws_d_r  <= word_sync;
         if (ws_fall) begin
            hold_r <= shift_r;
         end
         xfer_r  <= ws_fall;
      end
   end

   assign mute_on = ~ctl_s.mute_n | ctl_s.smute | ~ctl_s.por_ok;

   assign mode = mute_on         ? dsw_pkg::MODE_MUTE :
                 !ctl_s.freset_n ? (ctl_s.bypass_n ? dsw_pkg::MODE_INIT
                                                   : dsw_pkg::MODE_STD) :
                 (ctl_s.bypass_n ? dsw_pkg::MODE_FILT : dsw_pkg::MODE_BYP);

   // Pin code 0..3 selects ratio 2, 4, 8, 16
   assign ratio_log2 = 3'({1'b0, ctl_s.ratio}) + 3'h1;
   assign f_clr    = ~ctl_s.freset_n;
   assign f_load   = xfer_r & ctl_s.freset_n;

   dsw_interp #(
      .W     (W),
      .ACC_W (dsw_pkg::ACC_W)
   ) u_interp (
      .clk      (clk_bit),
      .rst      (rst),
      .clr      (f_clr),
      .load     (f_load),
      .sample   (hold_r),
      .ratio_log2 (ratio_log2),
      .code     (f_code),
      .tick     (f_tick)
   );

   always_comb begin
      dac_nxt = dac_code_r;
      upd_nxt = 1'b0;
      case (mode)
         dsw_pkg::MODE_MUTE: begin
            if (xfer_r) begin
               dac_nxt = dsw_pkg::MID_CODE;
               upd_nxt = 1'b1;
            end
         end
         dsw_pkg::MODE_STD: begin
            if (xfer_r) begin
               dac_nxt = hold_r;
               upd_nxt = 1'b1;
            end
         end
         dsw_pkg::MODE_BYP: begin
            if (xfer_r) begin
               dac_nxt = hold_r;
               upd_nxt = 1'b1;
            end
         end
         dsw_pkg::MODE_INIT: begin
            dac_nxt = dsw_pkg::MID_CODE;
            upd_nxt = (dac_code_r != dsw_pkg::MID_CODE);
         end
         dsw_pkg::MODE_FILT: begin
            if (f_tick) begin
               dac_nxt = f_code;
               upd_nxt = 1'b1;
            end
         end
         default: begin
            dac_nxt = dsw_pkg::MID_CODE;
            upd_nxt = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_bit or posedge rst) begin
      if (rst) begin
         dac_code_r   <= dsw_pkg::MID_CODE;
         dac_update_r <= 1'b0;
         snap_r       <= '0;
         ack_r        <= 1'b0;
      end else begin
         dac_code_r   <= dac_nxt;
         dac_update_r <= upd_nxt;
         if (ctl_s.req != ack_r) begin
            snap_r <= {mode, dac_code_r};
            ack_r  <= ctl_s.req;
         end
      end
   end

   assign dac_code   = dac_code_r;
   assign dac_update = dac_update_r;

   // Only the shift check below reads this
   always_ff @(posedge clk_bit or posedge rst) begin
      if (rst) begin
         warm_r <= 5'h00;
      end else if (warm_r != 5'h10) begin
         warm_r <= warm_r + 5'h01;
      end
   end

   property p_shift;
      @(posedge clk_bit) disable iff (rst)
      (warm_r == 5'h10) |-> shift_r[W-1] == $past(serial_data_in, 16);
   endproperty
   a_shift: assert property (p_shift) else $error("msb is not the bit of 16 edges ago");

   property p_capture;
      @(posedge clk_bit) disable iff (rst)
      ws_fall |=> (hold_r == $past(shift_r)) && xfer_r;
   endproperty
   a_capture: assert property (p_capture) else $error("word sync fall did not capture");

   property p_keep;
      @(posedge clk_bit) disable iff (rst)
      !ws_fall |=> $stable(hold_r);
   endproperty
   a_keep: assert property (p_keep) else $error("holding register changed between falls");

   property p_std;
      @(posedge clk_bit) disable iff (rst)
      ws_fall ##1 (mode == dsw_pkg::MODE_STD)
      |=> dac_update && (dac_code == $past(hold_r));
   endproperty
   a_std: assert property (p_std) else $error("standard update not on second edge");

   property p_quiet;
      @(posedge clk_bit) disable iff (rst)
      (mode == dsw_pkg::MODE_STD && !xfer_r) |=> !dac_update && $stable(dac_code);
   endproperty
   a_quiet: assert property (p_quiet) else $error("latch moved outside the transfer edge");

   property p_mute;
      @(posedge clk_bit) disable iff (rst)
      (xfer_r && mode == dsw_pkg::MODE_MUTE) |=> dac_code == dsw_pkg::MID_CODE;
   endproperty
   a_mute: assert property (p_mute) else $error("mute did not force mid-scale");

   property p_byp;
      @(posedge clk_bit) disable iff (rst)
      (xfer_r && mode == dsw_pkg::MODE_BYP) |=> dac_code == $past(hold_r);
   endproperty
   a_byp: assert property (p_byp) else $error("bypass did not load the held word");

   property p_por;
      @(posedge clk_bit) disable iff (rst)
      !ctl_s.por_ok |=> dac_code == dsw_pkg::MID_CODE;
   endproperty
   a_por: assert property (p_por) else $error("output left mid-scale before power-on delay");

   property p_por_time;
      @(posedge clk_sys) disable iff (rst)
      (por_cnt_r == dsw_pkg::POR_W'(dsw_pkg::POR_CYC - 2)) |-> !por_done ##1 !por_done ##1 por_done;
   endproperty
   a_por_time: assert property (p_por_time) else $error("power-on delay count wrong");

   c_std: cover property (@(posedge clk_bit) disable iff (rst)
      xfer_r && mode == dsw_pkg::MODE_STD);
   c_filt: cover property (@(posedge clk_bit) disable iff (rst)
      f_tick && mode == dsw_pkg::MODE_FILT);
   c_mute: cover property (@(posedge clk_bit) disable iff (rst)
      xfer_r && mode == dsw_pkg::MODE_MUTE && ctl_s.por_ok);
   c_fullscale: cover property (@(posedge clk_bit) disable iff (rst)
      dac_code == dsw_pkg::POS_FS ##[1:64] dac_code == dsw_pkg::NEG_FS);
endmodule
`default_nettype wire

// file: inc/dsw_pkg.sv
// Purpose: Shared constants and types for the serial word input block
// Assumes: 20 MHz system clock, 16-bit two's complement samples
// Notes:   Register offsets are byte addresses of 32-bit words
package dsw_pkg;
   localparam int WORD_W      = 16;
   localparam int ACC_W       = 28;
   localparam int FRAME_EDGES = 16;
   localparam int SYS_HZ      = 20_000_000;
   localparam int POR_US      = 30;
   // Least time, so round up to whole cycles
   localparam int POR_CYC     = (POR_US * SYS_HZ + 999_999) / 1_000_000;
   localparam int POR_W       = 10;
   localparam int ADDR_W      = 4;
   localparam int DATA_W      = 32;

   localparam logic [15:0] MID_CODE = 16'h0000;
   localparam logic [15:0] POS_FS   = 16'h7fff;
   localparam logic [15:0] NEG_FS   = 16'h8000;

   localparam logic [3:0] OFF_CTRL = 4'h0;
   localparam logic [3:0] OFF_CODE = 4'h4;
   localparam logic [3:0] OFF_STAT = 4'h8;
   localparam int         CTRL_SMUTE_BIT = 0;
   localparam logic       CTRL_SMUTE_RST = 1'b0;
   localparam int         STAT_POR_BIT   = 0;
   localparam int         STAT_MODE_LSB  = 1;

   typedef enum logic [2:0] {
      MODE_MUTE = 3'b000,
      MODE_STD  = 3'b001,
      MODE_INIT = 3'b010,
      MODE_BYP  = 3'b011,
      MODE_FILT = 3'b100
   } dsw_mode_t;

   typedef enum logic {
      POR_WAIT = 1'b0,
      POR_DONE = 1'b1
   } dsw_por_t;

   typedef struct packed {
      logic       mute_n;
      logic       bypass_n;
      logic       freset_n;
      logic [1:0] ratio;
      logic       smute;
      logic       por_ok;
      logic       req;
   } dsw_ctl_t;

   typedef struct packed {
      dsw_mode_t   mode;
      logic [15:0] code;
   } dsw_snap_t;
endpackage

// file: tb/dsw_host.sv
// Purpose: Host model driving bit clock, word sync and serial data
// Assumes: Bit clock runs free, since the filter needs it continuous
// Notes:   Lines change on falling edges, clear of the sampling rise
`timescale 1ns/1ps
`default_nettype none
module dsw_host (
   output logic clk_bit,
   output logic serial_data_in,
   output logic word_sync
);
   logic busy;

   initial begin
      clk_bit = 1'b0;
      serial_data_in = 1'b0;
      word_sync = 1'b0;
      busy = 1'b0;
   end

   always #6 clk_bit = ~clk_bit;

   // Idle data keeps moving so a stale bit never looks valid
   always @(negedge clk_bit) begin
      if (!busy) begin
         word_sync <= 1'b0;
         serial_data_in <= ~serial_data_in;
      end
   end

   // Sync low on the first bit, so the next frame start is the fall
   task automatic send(input logic [31:0] w, input int n);
      busy = 1'b1;
      for (int i = n - 1; i >= 0; i--) begin
         @(negedge clk_bit);
         serial_data_in <= w[i];
         word_sync <= (i != n - 1);
      end
      @(posedge clk_bit);
      busy = 1'b0;
   endtask
endmodule
`default_nettype wire

// file: tb/dsw_top_test.sv
// Purpose: Self-checking bench for the serial word input block
// Assumes: Host model owns the bit clock and the serial lines
// Notes:   Control pins need a few bit clocks to pass the synchroniser
`timescale 1ns/1ps
`default_nettype none
module dsw_top_test;
   logic        clk_sys;
   logic        rst;
   logic        clk_bit;
   logic        serial_data_in;
   logic        word_sync;
   logic        mute_n;
   logic        filter_bypass_n;
   logic        filter_reset_n;
   logic [1:0]  oversampling_ratio;
   logic [3:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [31:0] reg_rdata;
   logic [15:0] dac_code;
   logic        dac_update;
   logic [31:0] rd;
   logic        ws_q;
   logic        chk_lat;
   int          n_mismatch;
   int          checks_done;
   int          cyc;
   int          rel_cyc;
   int          upd_cnt;
   int          since_fall;

   dsw_top u_dsw_top (
      .clk_sys(clk_sys), .rst(rst), .clk_bit(clk_bit),
      .serial_data_in(serial_data_in), .word_sync(word_sync),
      .mute_n(mute_n), .filter_bypass_n(filter_bypass_n),
      .filter_reset_n(filter_reset_n), .oversampling_ratio(oversampling_ratio),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dac_code(dac_code),
      .dac_update(dac_update)
   );
   dsw_host u_dsw_host (
      .clk_bit(clk_bit), .serial_data_in(serial_data_in), .word_sync(word_sync)
   );

   always #25 clk_sys = ~clk_sys;

   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 6000) begin
         n_mismatch++;
         report_and_stop();
      end
   end

   // Rises since the last sync fall; the update is sampled two rises on
   always @(posedge clk_bit) begin
      if (dac_update === 1'b1) upd_cnt++;
      since_fall = (ws_q === 1'b1 && word_sync === 1'b0) ? 0 : since_fall + 1;
      ws_q = word_sync;
      if (chk_lat && dac_update === 1'b1) check("update latency", 32'h2, since_fall);
   end

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(posedge clk_sys);
      d = reg_rdata;
   endtask

   task automatic set_pins(input logic m, input logic b, input logic f, input logic [1:0] o);
      @(posedge clk_sys);
      mute_n <= m;
      filter_bypass_n <= b;
      filter_reset_n <= f;
      oversampling_ratio <= o;
      repeat (8) @(posedge clk_bit);
   endtask

   // Snapshot round trip through both synchronisers can take a dozen cycles
   task automatic stat_check(input logic [3:0] exp);
      repeat (16) @(posedge clk_sys);
      reg_read(dsw_pkg::OFF_STAT, rd);
      check("status", {28'h0, exp}, rd);
   endtask

   task automatic word_check(input logic [31:0] w, input int n, input logic [15:0] exp);
      logic found;
      found = 1'b0;
      u_dsw_host.send(w, n);
      for (int i = 0; i < 64 && !found; i++) begin
         @(posedge clk_bit);
         found = (dac_update === 1'b1);
      end
      check("update seen", 32'h1, {31'h0, found});
      check("dac code", {16'h0, exp}, {16'h0, dac_code});
   endtask

   task automatic count_window(input int exp);
      @(negedge clk_bit);
      upd_cnt = 0;
      repeat (32) @(posedge clk_bit);
      @(negedge clk_bit);
      check("updates in 32 rises", exp, upd_cnt);
   endtask

   task automatic report_and_stop();
      $display("Counts: %0d checks, %0d mismatches", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      clk_sys = 1'b0;
      rst = 1'b1;
      mute_n = 1'b1;
      filter_bypass_n = 1'b0;
      filter_reset_n = 1'b0;
      oversampling_ratio = 2'h0;
      reg_addr = 4'h0;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      n_mismatch = 0;
      checks_done = 0;
      cyc = 0;
      upd_cnt = 0;
      since_fall = 0;
      chk_lat = 1'b0;
      repeat (4) @(posedge clk_sys);
      check("code in reset", 32'h0, {16'h0, dac_code});
      rst <= 1'b0;
      rel_cyc = cyc;
      reg_read(dsw_pkg::OFF_STAT, rd);
      check("status early", 32'h0, rd);
      reg_read(dsw_pkg::OFF_CTRL, rd);
      check("ctrl reset", 32'h0, rd);
      word_check(32'h1234, 16, dsw_pkg::MID_CODE);
      for (int i = 0; i < 400 && rd[0] !== 1'b1; i++) reg_read(dsw_pkg::OFF_STAT, rd);
      check("power-on wait", 32'h1, {31'h0, (cyc - rel_cyc) >= dsw_pkg::POR_CYC});
      $display("Test power-on done");

      set_pins(1'b1, 1'b0, 1'b0, 2'h0);
      stat_check(4'h3);
      chk_lat = 1'b1;
      word_check(32'h7fff, 16, dsw_pkg::POS_FS);
      word_check(32'h8000, 16, dsw_pkg::NEG_FS);
      word_check(32'h0000, 16, dsw_pkg::MID_CODE);
      word_check(32'ha5c3, 16, 16'ha5c3);
      word_check(32'hf3c96, 20, 16'h3c96);
      repeat (8) @(posedge clk_bit);
      count_window(0);
      check("held code", 32'h3c96, {16'h0, dac_code});
      repeat (8) @(posedge clk_sys);
      reg_write(dsw_pkg::OFF_CODE, 32'hffff);
      reg_read(dsw_pkg::OFF_CODE, rd);
      check("code register", 32'h3c96, rd);
      reg_read(4'hc, rd);
      check("unmapped read", 32'h0, rd);
      $display("Test standard mode done");

      set_pins(1'b0, 1'b0, 1'b0, 2'h0);
      stat_check(4'h1);
      word_check(32'h4321, 16, dsw_pkg::MID_CODE);
      set_pins(1'b1, 1'b0, 1'b0, 2'h0);
      word_check(32'h2468, 16, 16'h2468);
      reg_write(dsw_pkg::OFF_CTRL, 32'h1);
      reg_read(dsw_pkg::OFF_CTRL, rd);
      check("soft mute", 32'h1, rd);
      stat_check(4'h1);
      word_check(32'h4321, 16, dsw_pkg::MID_CODE);
      reg_write(dsw_pkg::OFF_CTRL, 32'h0);
      word_check(32'h4321, 16, 16'h4321);
      $display("Test mute done");

      chk_lat = 1'b0;
      set_pins(1'b1, 1'b1, 1'b0, 2'h0);
      stat_check(4'h5);
      u_dsw_host.send(32'h6655, 16);
      repeat (4) @(posedge clk_bit);
      check("filter init code", 32'h0, {16'h0, dac_code});
      set_pins(1'b1, 1'b0, 1'b1, 2'h0);
      stat_check(4'h7);
      chk_lat = 1'b1;
      word_check(32'h1357, 16, 16'h1357);
      chk_lat = 1'b0;
      $display("Test init and bypass done");

      // Ramp input keeps every interpolated point distinct
      for (int r = 0; r < 4; r++) begin
         set_pins(1'b1, 1'b1, 1'b0, r[1:0]);
         set_pins(1'b1, 1'b1, 1'b1, r[1:0]);
         stat_check(4'h9);
         fork
            for (int k = 0; k < 6; k++) u_dsw_host.send(k * 32'h0800, 16);
            begin
               repeat (40) @(posedge clk_bit);
               count_window(4 << r);
            end
         join
      end
      $display("Test filter ratios done");
      report_and_stop();
   end
endmodule
`default_nettype wire
